/* testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  import tetp_pkg::*;
  localparam int T = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, hot, offs, ack, pin, pin_oe, tach, al_oe;
  logic        p_o, a_o;
  logic [3:0]  sel, fans, ovr;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  v;
  tetp_temp_s  temps;
  int          errors = 0;
  int          checked = 0;
  logic [7:0]  rw [10] = '{8'h5F, 8'h60, 8'h61, 8'h6A, 8'h6B, 8'h6C,
                           8'h75, 8'h78, 8'h7A, 8'h7D};
  always #50 clk_i = ~clk_i;
  tetp_timer_pin #(.NFANS(4), .TICK_CYCLES(T)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .temps_i(temps), .offset64_i(offs), .fan_running_i(fans),
    .full_speed_override_o(ovr), .thermal_event_pin_i(pin),
    .thermal_event_pin_o(p_o), .thermal_event_pin_oe_o(pin_oe),
    .tach_input_four_o(tach), .alert_pin_o(a_o), .alert_pin_oe_o(al_oe));
  tetp_hot_src u_src (.hot_i(hot), .dut_oe_i(pin_oe), .pin_o(pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, i, 8'h00, r);
    `CHK(r, e)
  endtask : rdc
  function automatic logic [7:0] texp(input int n);
    int u;
    u = n / T;
    if (u > 255) u = 255;
    if (u < 1) u = 1;
    return 8'(u);
  endfunction : texp
  // prescaler phase is hidden, so one tick short is accepted
  task automatic tchk(input int n);
    logic [7:0] r;
    logic [7:0] e;
    e = texp(n);
    bus(1'b0, IDX_TIMER, 8'h00, r);
    `CHK((r == e) || (r == e - 8'h01), 1'b1)
  endtask : tchk
  task automatic pulse(input int n);
    @(posedge clk_i) hot <= 1'b1;
    repeat (n) @(posedge clk_i);
    hot <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : pulse
  task automatic tmp(input int c, input logic [9:0] t);
    @(posedge clk_i);
    temps.temp[c] <= t;
    temps.valid[c] <= 1'b1;
    @(posedge clk_i) temps.valid <= 3'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : tmp
  task complete_run;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    errors++;
    complete_run();
  end
  initial begin
    {cyc, stb, we, hot, adr, wdat, fans} = '0;
    offs = 1'b1;
    sel = 4'hF;
    temps = '0;
    void'($urandom(32'h4974));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rw[k]) rdc(rw[k], RST_REG);
    rdc(IDX_TIMER, RST_REG);
    #1 `CHK({ovr, pin_oe, al_oe}, 6'h00)
    `CHK({p_o, a_o}, 2'h0)
    foreach (rw[k]) begin
      v = 8'($urandom);
      wr(rw[k], v);
      rdc(rw[k], v);
      wr(rw[k], RST_REG);
    end
    rdc(8'h10, RST_REG);
    wr(IDX_CFG_A, 8'h02);
    @(posedge clk_i) hot <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 `CHK(tach, 1'b0)
    @(posedge clk_i) hot <= 1'b0;
    rdc(IDX_TIMER, RST_REG);
    wr(IDX_CFG_B, {6'h0, FUNC_THERMAL_EVENT_PIN});
    wr(IDX_CFG_A, 8'h03);
    pulse(3 * T);
    `CHK(al_oe, 1'b1)
    rdc(IDX_INT_STS2, 8'h20);
    tchk(3 * T);
    rdc(IDX_INT_STS2, 8'h20);
    #1 `CHK(al_oe, 1'b0)
    pulse(2 * T);
    pulse(2 * T);
    tchk(4 * T);
    pulse(300 * T);
    tchk(300 * T);
    rdc(IDX_TIMER, RST_REG);
    @(posedge clk_i) hot <= 1'b1;
    repeat (3 * T) @(posedge clk_i);
    tchk(3 * T);
    rdc(IDX_TIMER, TIMER_FIRST);
    @(posedge clk_i) hot <= 1'b0;
    rdc(IDX_INT_STS2, 8'h20);
    rdc(IDX_TIMER, TIMER_FIRST);
    rdc(IDX_INT_STS2, 8'h20);
    wr(IDX_MASK2, 8'h20);
    pulse(T);
    `CHK(al_oe, 1'b0)
    rdc(IDX_INT_STS2, 8'h20);
    tchk(T);
    rdc(IDX_INT_STS2, 8'h20);
    wr(IDX_MASK2, RST_REG);
    wr(IDX_TLIM, 8'h01);
    pulse(T);
    rdc(IDX_INT_STS2, 8'h00);
    pulse(3 * T);
    rdc(IDX_INT_STS2, 8'h20);
    wr(IDX_CFG_A, 8'h06);
    repeat (4) begin
      @(posedge clk_i);
      fans <= 4'($urandom);
      hot <= 1'b1;
      @(posedge clk_i);
      #1 `CHK(ovr, fans)
      @(posedge clk_i) hot <= 1'b0;
      @(posedge clk_i);
      #1 `CHK(ovr, 4'h0)
    end
    wr(IDX_CFG_A, 8'h02);
    @(posedge clk_i) hot <= 1'b1;
    @(posedge clk_i);
    #1 `CHK(ovr, 4'h0)
    @(posedge clk_i) hot <= 1'b0;
    for (int c = 0; c < NCH; c++) begin
      wr(8'(IDX_R1_CFG + c), 8'h08);
      wr(8'(IDX_R1_CRIT + c), 8'h90);
      tmp(c, {8'h90, 2'h1});
      `CHK(pin_oe, 1'b1)
      repeat (8) @(posedge clk_i);
      #1 `CHK(pin_oe, 1'b1)
      tmp(c, {8'h90, 2'h0});
      `CHK(pin_oe, 1'b0)
    end
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_i) offs <= f[0];
      wr(IDX_R1_CRIT, CRIT_FLOOR_64);
      tmp(0, {8'h90, 2'h1});
      `CHK(pin_oe, 1'b0)
    end
    // flag is still set from the last overrun: shared pin carries alert
    wr(IDX_CFG_B, {6'h0, FUNC_ALERT});
    #1 `CHK(pin_oe, 1'b1)
    wr(IDX_CFG_B, {6'h0, FUNC_GPIO});
    #1 `CHK(pin_oe, 1'b0)
    // lane 0 not selected: write must be dropped
    @(posedge clk_i) sel <= 4'hE;
    wr(IDX_TLIM, 8'h55);
    @(posedge clk_i) sel <= 4'hF;
    rdc(IDX_TLIM, 8'h01);
    complete_run();
  end
endmodule : testbench

/* tetp_hot_src.sv */
`timescale 1ns/10ps
module tetp_hot_src (
  input  wire logic hot_i,
  input  wire logic dut_oe_i,
  output logic      pin_o
);
  // open-drain line with pull-up: either party may pull it low
  assign pin_o = ~(hot_i | dut_oe_i);
endmodule : tetp_hot_src

/* tetp_pkg.sv */
package tetp_pkg;

  localparam int       ADR_W          = 10;
  localparam int       NCH            = 3;
  localparam int       PRESC_W        = 18;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_R1_CFG    = 8'h5F;
  localparam logic [7:0] IDX_LOC_CFG   = 8'h60;
  localparam logic [7:0] IDX_R2_CFG    = 8'h61;
  localparam logic [7:0] IDX_R1_CRIT   = 8'h6A;
  localparam logic [7:0] IDX_LOC_CRIT  = 8'h6B;
  localparam logic [7:0] IDX_R2_CRIT   = 8'h6C;
  localparam logic [7:0] IDX_INT_STS2  = 8'h42;
  localparam logic [7:0] IDX_MASK2     = 8'h75;
  localparam logic [7:0] IDX_CFG_A     = 8'h78;
  localparam logic [7:0] IDX_TIMER     = 8'h79;
  localparam logic [7:0] IDX_TLIM      = 8'h7A;
  localparam logic [7:0] IDX_CFG_B     = 8'h7D;

  localparam int       CFGA_ALERT_EN  = 0;
  localparam int       CFGA_THERMAL_EVENT_PIN_EN  = 1;
  localparam int       CFGA_OVERRIDE  = 2;
  localparam int       CH_OUT_EN      = 3;
  localparam int       F4P_BIT        = 5;

  localparam logic [1:0] FUNC_TACH     = 2'h0;
  localparam logic [1:0] FUNC_THERMAL_EVENT_PIN    = 2'h1;
  localparam logic [1:0] FUNC_ALERT    = 2'h2;
  localparam logic [1:0] FUNC_GPIO     = 2'h3;

  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] TIMER_FULL    = 8'hFF;
  localparam logic [7:0] TIMER_FIRST   = 8'h01;
  localparam logic [7:0] CRIT_FLOOR_64 = 8'h80;
  localparam logic [1:0] FRAC_ZERO     = 2'h0;

  localparam real      CLK_NS         = 100.0;
  localparam real      TICK_MS        = 22.76;
  localparam int       TICK_CYC       = int'(TICK_MS * 1.0e6 / CLK_NS);

  typedef struct packed {
    logic                        ack;
    logic [7:0]                  rdata;
    logic [NCH-1:0][7:0]         ch_cfg;
    logic [NCH-1:0][7:0]         crit;
    logic [7:0]                  mask2;
    logic [7:0]                  cfg_a;
    logic [7:0]                  cfg_b;
    logic [7:0]                  tlim;
    logic [7:0]                  units;
    logic                        seen;
    logic [PRESC_W-1:0]          presc;
    logic                        flag;
    logic [NCH-1:0]              hot;
  } tetp_state_s;

  typedef struct packed {
    logic [NCH-1:0][9:0]         temp;
    logic [NCH-1:0]              valid;
  } tetp_temp_s;

endpackage : tetp_pkg

/* tetp_timer_pin.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
module tetp_timer_pin #(
  parameter int NFANS       = 4,
  parameter int TICK_CYCLES = tetp_pkg::TICK_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [tetp_pkg::ADR_W-1:0] adr_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  input  wire tetp_pkg::tetp_temp_s     temps_i,
  input  wire logic                     offset64_i,
  input  wire logic [NFANS-1:0]         fan_running_i,
  output logic      [NFANS-1:0]         full_speed_override_o,
  input  wire logic                     thermal_event_pin_i,
  output logic                          thermal_event_pin_o,
  output logic                          thermal_event_pin_oe_o,
  output logic                          tach_input_four_o,
  output logic                          alert_pin_o,
  output logic                          alert_pin_oe_o
);
  import tetp_pkg::*;

  tetp_state_s s_q;
  tetp_state_s s_d;

  logic [7:0] idx;
  logic       rd_take;
  logic       wr_take;
  logic       thermal_event_pin_sel;
  logic       asserted;
  logic       exceed;
  logic       alert;
  logic [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] disp(input logic [7:0] u, input logic seen);
    disp = (u == RST_REG && seen) ? TIMER_FIRST : u;
  endfunction : disp

  // two's complement codes are folded so one unsigned compare serves both
  function automatic logic [7:0] ord(input logic [7:0] v, input logic off64);
    ord = off64 ? v : {~v[7], v[6:0]};
  endfunction : ord

  function automatic logic crit_ok(input logic [7:0] lim, input logic off64);
    crit_ok = off64 ? (lim > CRIT_FLOOR_64) : ~lim[7];
  endfunction : crit_ok

  ////////////////////////////////////////////////////////////////////////////
  assign idx       = adr_i[ADR_W-1:2];
  assign rd_take   = cyc_i & stb_i & ~we_i & ~s_q.ack;
  assign wr_take   = cyc_i & stb_i & we_i & s_q.ack & sel_i[0];
  assign wbyte     = dat_i[7:0];
  assign thermal_event_pin_sel = (s_q.cfg_b[1:0] == FUNC_THERMAL_EVENT_PIN);
  assign asserted  = thermal_event_pin_sel & s_q.cfg_a[CFGA_THERMAL_EVENT_PIN_EN]
                   & ~thermal_event_pin_i;
  assign exceed    = disp(s_q.units, s_q.seen) > s_q.tlim;
  assign alert     = s_q.flag & ~s_q.mask2[F4P_BIT];

  always_comb begin
    s_d     = s_q;
    s_d.ack = cyc_i & stb_i & ~s_q.ack;

    if (rd_take) begin
      case (idx)
        IDX_R1_CFG:   s_d.rdata = s_q.ch_cfg[0];
        IDX_LOC_CFG:  s_d.rdata = s_q.ch_cfg[1];
        IDX_R2_CFG:   s_d.rdata = s_q.ch_cfg[2];
        IDX_R1_CRIT:  s_d.rdata = s_q.crit[0];
        IDX_LOC_CRIT: s_d.rdata = s_q.crit[1];
        IDX_R2_CRIT:  s_d.rdata = s_q.crit[2];
        IDX_INT_STS2: s_d.rdata = 8'(s_q.flag) << F4P_BIT;
        IDX_MASK2:    s_d.rdata = s_q.mask2;
        IDX_CFG_A:    s_d.rdata = s_q.cfg_a;
        IDX_TIMER:    s_d.rdata = disp(s_q.units, s_q.seen);
        IDX_TLIM:     s_d.rdata = s_q.tlim;
        IDX_CFG_B:    s_d.rdata = s_q.cfg_b;
        default:      s_d.rdata = RST_REG;
      endcase
    end

    if (wr_take) begin
      case (idx)
        IDX_R1_CFG:   s_d.ch_cfg[0] = wbyte;
        IDX_LOC_CFG:  s_d.ch_cfg[1] = wbyte;
        IDX_R2_CFG:   s_d.ch_cfg[2] = wbyte;
        IDX_R1_CRIT:  s_d.crit[0]   = wbyte;
        IDX_LOC_CRIT: s_d.crit[1]   = wbyte;
        IDX_R2_CRIT:  s_d.crit[2]   = wbyte;
        IDX_MASK2:    s_d.mask2     = wbyte;
        IDX_CFG_A:    s_d.cfg_a     = wbyte;
        IDX_TLIM:     s_d.tlim      = wbyte;
        IDX_CFG_B:    s_d.cfg_b     = wbyte;
        default:      s_d.mask2     = s_q.mask2;
      endcase
    end

    // clear first so an assertion in the read cycle restarts at bit 0
    if (rd_take && idx == IDX_TIMER) begin
      s_d.units = RST_REG;
      s_d.seen  = 1'b0;
      s_d.presc = '0;
    end
    if (asserted) begin
      s_d.seen = 1'b1;
      if (s_d.presc == PRESC_W'(TICK_CYCLES - 1)) begin
        s_d.presc = '0;
        if (s_d.units != TIMER_FULL) begin
          s_d.units = s_d.units + 8'h01;
        end
      end else begin
        s_d.presc = s_d.presc + PRESC_W'(1);
      end
    end

    // flag: read clears only once condition gone; set wins the same cycle
    if (rd_take && idx == IDX_INT_STS2 && !exceed) begin
      s_d.flag = 1'b0;
    end
    if (exceed) begin
      s_d.flag = 1'b1;
    end

    // hot level is set only on a fresh measurement of its own channel; it clears at once when the channel is disabled or its limit is invalid
    for (int c = 0; c < NCH; c++) begin
      if (!(s_q.ch_cfg[c][CH_OUT_EN] && crit_ok(s_q.crit[c], offset64_i)))
        begin
        s_d.hot[c] = 1'b0;
      end else if (temps_i.valid[c]) begin
        s_d.hot[c] = {ord(temps_i.temp[c][9:2], offset64_i),
                      temps_i.temp[c][1:0]} >
                     {ord(s_q.crit[c], offset64_i), FRAC_ZERO};
      end
    end

    if (rst_i) begin
      s_d        = '0;
      s_d.cfg_a  = RST_REG;
      s_d.cfg_b  = RST_REG;
      s_d.tlim   = RST_REG;
      s_d.mask2  = RST_REG;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ack_o  = s_q.ack;
  assign dat_o  = {24'h000000, s_q.rdata};

  // override only lifts fans that are already turning
  assign full_speed_override_o = (s_q.cfg_a[CFGA_OVERRIDE] && asserted) ?
                                 fan_running_i : '0;

  // open drain: output level is always low, enable does the work
  assign thermal_event_pin_o    = 1'b0;
  assign thermal_event_pin_oe_o = (thermal_event_pin_sel & (|s_q.hot))
                                | ((s_q.cfg_b[1:0] == FUNC_ALERT) & alert);
  assign tach_input_four_o      = (s_q.cfg_b[1:0] == FUNC_TACH) ?
                                  thermal_event_pin_i : 1'b1;
  assign alert_pin_o            = 1'b0;
  assign alert_pin_oe_o         = s_q.cfg_a[CFGA_ALERT_EN] & alert;

  ////////////////////////////////////////////////////////////////////////////
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single cycle pulse");

  property p_read_restart;
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_TIMER && asserted && s_q.presc != '0)
      |=> (s_q.seen && s_q.units == RST_REG);
  endproperty
  a_read_restart: assert property (p_read_restart)
    else $error("timer read during assertion did not restart");

  property p_pause;
    @(posedge clk_i) disable iff (rst_i)
    (!asserted && !(rd_take && idx == IDX_TIMER)) |=>
      ($stable(s_q.units) && $stable(s_q.presc));
  endproperty
  a_pause: assert property (p_pause)
    else $error("timer moved while input idle");

  property p_full_hold;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.units == TIMER_FULL && !(rd_take && idx == IDX_TIMER))
      |=> s_q.units == TIMER_FULL;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("timer left full scale without read");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    exceed |=> s_q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag missed a limit overrun");

  property p_mask;
    @(posedge clk_i) disable iff (rst_i)
    s_q.mask2[F4P_BIT] |-> !alert_pin_oe_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked overrun drove alert");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.flag && !(rd_take && idx == IDX_INT_STS2)) |=> s_q.flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a status read");

  property p_override;
    @(posedge clk_i) disable iff (rst_i)
    !s_q.cfg_a[CFGA_OVERRIDE] |-> full_speed_override_o == '0;
  endproperty
  a_override: assert property (p_override)
    else $error("fans forced with override off");

  property p_not_thermal_event_pin;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.cfg_b[1:0] == FUNC_TACH || s_q.cfg_b[1:0] == FUNC_GPIO)
      |-> (!thermal_event_pin_oe_o && !asserted);
  endproperty
  a_not_thermal_event_pin: assert property (p_not_thermal_event_pin)
    else $error("shared pin used outside thermal function");

  property p_hot_hold;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.hot[0] && !temps_i.valid[0] && s_q.ch_cfg[0][CH_OUT_EN]
     && $stable(s_q.crit[0]) && $stable(offset64_i)) |=> s_q.hot[0];
  endproperty
  a_hot_hold: assert property (p_hot_hold)
    else $error("pin released between measurements");

  property p_reset_off;
    @(posedge clk_i)
    rst_i |=> (!asserted && s_q.cfg_b == RST_REG);
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("monitoring active after reset");

endmodule : tetp_timer_pin
